/* File: logic/lab_pkg.sv */
/*
  Package for the local advancement and error-rate register bank.
  Assumes a 16-bit word-addressed register port on the system clock.
*/
package lab_pkg;
  // ****************************************
  // Register offsets (word addresses)
  // ****************************************
  localparam logic [15:0] ADDR_ADV_LO    = 16'h0020;
  localparam logic [15:0] ADDR_ADV_HI    = 16'h0021;
  localparam logic [15:0] ADDR_LOC_SEL   = 16'h0027;
  localparam logic [15:0] ADDR_BKP_SEL   = 16'h0029;
  localparam logic [15:0] ADDR_LOC_COUNT = 16'h0028;
  localparam logic [15:0] ADDR_BKP_COUNT = 16'h002A;
  localparam logic [15:0] ADDR_COUNT_CLR = 16'h002C;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int          LOC_SEL_W    = 12;
  localparam int          BKP_SEL_W    = 13;
  localparam int          STREAMS      = 16;
  localparam logic [15:0] RESET_VALUE  = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [15:0] UNMAPPED_VAL = 16'h0000;

  // ****************************************
  // Advancement times and cycle counts
  // ****************************************
  localparam real         CLK_NS       = 50.0;
  localparam real         ADV_STEP_NS  = 7.5;
  localparam int          ADV_STEP_CYC = (ADV_STEP_NS < CLK_NS) ? 1 : int'(ADV_STEP_NS / CLK_NS);

  typedef enum logic [1:0]
  {
    LAB_ADV_NONE = 2'h0,
    LAB_ADV_1    = 2'h1,
    LAB_ADV_2    = 2'h2,
    LAB_ADV_3    = 2'h3
  } lab_adv_type;
endpackage : lab_pkg

/* File: logic/lab_err_if.sv */
/*
  Interface carrying one error monitor's event and count.
  Assumes both ends sit on clk_sys.
*/
interface lab_err_if;
  logic        err_pulse;
  logic        clear;
  logic [15:0] count;
  modport bank (output err_pulse, output clear, input count);
  modport counter (input err_pulse, input clear, output count);
endinterface : lab_err_if

/* File: logic/lab_sat_counter.sv */
/*
  Saturating 16-bit error counter.
  Assumes error pulses synchronous to clk_sys.
*/
module lab_sat_counter
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // Event side
  lab_err_if.counter err
);
  logic [15:0] next_count;

  // ****************************************
  // Count, holding at full scale
  // ****************************************
  // Event in the clear cycle still counts
  assign next_count = err.clear ? (err.err_pulse ? 16'h0001 : lab_pkg::RESET_VALUE) :
                      (err.err_pulse && err.count != lab_pkg::COUNT_MAX) ? err.count + 16'h0001 :
                      err.count;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      err.count <= lab_pkg::RESET_VALUE;
    else if (clk_en)
      err.count <= next_count;
  end
endmodule : lab_sat_counter

/* File: logic/lab_regs.sv */
/*
  Register bank for local output advancement and error-rate monitoring.
  Assumes a one-cycle strobe register port and error pulses from the switch core.
*/
// The plain strobed port was decided locally.
// Contract
// - Each local output stream has a 2-bit advancement code of 0, 7.5, 15 or 22.5 ns.
// - The two advancement registers sit at 0x0020 and 0x0021 and reset to zero.
// - The local selection register holds a stream in bits 11-8 and a channel in bits 7-0.
// - The backplane selection register holds a stream in bits 12-8 and a channel in bits 7-0.
// - The local error counter is 16 bits and holds at 0xFFFF.
// - The backplane error counter is 16 bits and holds at 0xFFFF.
module lab_regs
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [15:0] reg_rdata,
  // Error events from checkers
  input  wire logic        local_err_event,
  input  wire logic        backplane_err_event,
  // Configuration out
  output      logic [31:0] stream_advance_code,
  output      logic [3:0]  local_err_stream_sel,
  output      logic [7:0]  local_err_channel_sel,
  output      logic [4:0]  backplane_err_stream_sel,
  output      logic [7:0]  backplane_err_channel_sel
);
  logic [15:0] local_out_advance_lo;
  logic [15:0] local_out_advance_hi;
  logic [15:0] local_err_input_select;
  logic [15:0] backplane_err_input_select;
  logic [15:0] next_rdata;
  logic        hit_adv_lo;
  logic        hit_adv_hi;
  logic        hit_loc_sel;
  logic        hit_bkp_sel;
  logic        hit_clr;
  logic        sel_adv_lo;
  logic        sel_adv_hi;
  logic        sel_loc_sel;
  logic        sel_bkp_sel;
  logic        sel_loc_count;
  logic        sel_bkp_count;
  logic        clr_local;
  logic        clr_backplane;
  logic [15:0] next_adv_lo;
  logic [15:0] next_adv_hi;
  logic [15:0] next_loc_select;
  logic [15:0] next_bkp_select;
  logic [31:0] next_advance_code;
  logic [3:0]  loc_stream_field;
  logic [7:0]  loc_channel_field;
  logic [4:0]  bkp_stream_field;
  logic [7:0]  bkp_channel_field;
  lab_err_if   loc_if ();
  lab_err_if   bkp_if ();

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
    hit = (addr == target);
  endfunction : hit

  // ****************************************
  // Address decode
  // ****************************************
  assign sel_adv_lo    = hit(reg_addr, lab_pkg::ADDR_ADV_LO);
  assign sel_adv_hi    = hit(reg_addr, lab_pkg::ADDR_ADV_HI);
  assign sel_loc_sel   = hit(reg_addr, lab_pkg::ADDR_LOC_SEL);
  assign sel_bkp_sel   = hit(reg_addr, lab_pkg::ADDR_BKP_SEL);
  assign sel_loc_count = hit(reg_addr, lab_pkg::ADDR_LOC_COUNT);
  assign sel_bkp_count = hit(reg_addr, lab_pkg::ADDR_BKP_COUNT);

  // ****************************************
  // Write strobes
  // ****************************************
  assign hit_adv_lo  = reg_wr && sel_adv_lo;
  assign hit_adv_hi  = reg_wr && sel_adv_hi;
  assign hit_loc_sel = reg_wr && sel_loc_sel;
  assign hit_bkp_sel = reg_wr && sel_bkp_sel;
  assign hit_clr     = reg_wr && hit(reg_addr, lab_pkg::ADDR_COUNT_CLR);

  // ****************************************
  // Writable registers
  // ****************************************
  assign next_adv_lo     = hit_adv_lo ? reg_wdata : local_out_advance_lo;
  assign next_adv_hi     = hit_adv_hi ? reg_wdata : local_out_advance_hi;
  assign next_loc_select = hit_loc_sel ? {4'h0, reg_wdata[lab_pkg::LOC_SEL_W-1:0]} :
                           local_err_input_select;
  assign next_bkp_select = hit_bkp_sel ? {3'h0, reg_wdata[lab_pkg::BKP_SEL_W-1:0]} :
                           backplane_err_input_select;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      local_out_advance_lo <= lab_pkg::RESET_VALUE;
    else if (clk_en)
      local_out_advance_lo <= next_adv_lo;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      local_out_advance_hi <= lab_pkg::RESET_VALUE;
    else if (clk_en)
      local_out_advance_hi <= next_adv_hi;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      local_err_input_select <= lab_pkg::RESET_VALUE;
    else if (clk_en)
      local_err_input_select <= next_loc_select;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      backplane_err_input_select <= lab_pkg::RESET_VALUE;
    else if (clk_en)
      backplane_err_input_select <= next_bkp_select;
  end

  // ****************************************
  // Error counters
  // ****************************************
  assign clr_local        = hit_clr && reg_wdata[0];
  assign clr_backplane    = hit_clr && reg_wdata[1];
  assign loc_if.err_pulse = local_err_event;
  assign loc_if.clear     = clr_local;
  assign bkp_if.err_pulse = backplane_err_event;
  assign bkp_if.clear     = clr_backplane;

  lab_sat_counter u_loc_count
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .err     (loc_if)
  );

  lab_sat_counter u_bkp_count
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .err     (bkp_if)
  );

  // ****************************************
  // Read mux and registered outputs
  // ****************************************
  assign next_rdata = sel_adv_lo    ? local_out_advance_lo :
                      sel_adv_hi    ? local_out_advance_hi :
                      sel_loc_sel   ? local_err_input_select :
                      sel_bkp_sel   ? backplane_err_input_select :
                      sel_loc_count ? loc_if.count :
                      sel_bkp_count ? bkp_if.count :
                      lab_pkg::UNMAPPED_VAL;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= lab_pkg::RESET_VALUE;
    else if (clk_en)
      reg_rdata <= reg_rd ? next_rdata : lab_pkg::RESET_VALUE;
  end

  // ****************************************
  // Advancement output
  // ****************************************
  assign next_advance_code = {local_out_advance_hi, local_out_advance_lo};

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      stream_advance_code <= 32'h0000_0000;
    else if (clk_en)
      stream_advance_code <= next_advance_code;
  end

  // ****************************************
  // Selection fields and outputs
  // ****************************************
  assign loc_stream_field  = local_err_input_select[11:8];
  assign loc_channel_field = local_err_input_select[7:0];
  assign bkp_stream_field  = backplane_err_input_select[12:8];
  assign bkp_channel_field = backplane_err_input_select[7:0];

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      local_err_stream_sel  <= 4'h0;
      local_err_channel_sel <= 8'h00;
    end
    else if (clk_en)
    begin
      local_err_stream_sel  <= loc_stream_field;
      local_err_channel_sel <= loc_channel_field;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      backplane_err_stream_sel  <= 5'h00;
      backplane_err_channel_sel <= 8'h00;
    end
    else if (clk_en)
    begin
      backplane_err_stream_sel  <= bkp_stream_field;
      backplane_err_channel_sel <= bkp_channel_field;
    end
  end
endmodule : lab_regs

/* File: dv/lab_regs_assertions.sv */
/*
  Port checker for the register bank.
  Assumes it is bound onto lab_regs and sees only its ports.
*/
module lab_regs_chk
(
  // Clock, reset and register port
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Events and configuration
  input wire logic        local_err_event,
  input wire logic        backplane_err_event,
  input wire logic [31:0] stream_advance_code,
  input wire logic [3:0]  local_err_stream_sel,
  input wire logic [7:0]  local_err_channel_sel,
  input wire logic [4:0]  backplane_err_stream_sel,
  input wire logic [7:0]  backplane_err_channel_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n || !clk_en);
  a_reset_zero: assert property ($rose(rst_n) |-> stream_advance_code == 32'h0)
    else $error("advancement not zero after reset");
  a_adv_lo_wr: assert property (reg_wr && reg_addr == 16'h0020 |-> ##2
    stream_advance_code[15:0] == $past(reg_wdata, 2)) else $error("low advancement mismatch");
  a_adv_hi_wr: assert property (reg_wr && reg_addr == 16'h0021 |-> ##2
    stream_advance_code[31:16] == $past(reg_wdata, 2)) else $error("high advancement mismatch");
  a_loc_sel_wr: assert property (reg_wr && reg_addr == 16'h0027 |-> ##2
    {local_err_stream_sel, local_err_channel_sel} == $past(reg_wdata[11:0], 2)) else $error("local select");
  a_bkp_sel_wr: assert property (reg_wr && reg_addr == 16'h0029 |-> ##2
    {backplane_err_stream_sel, backplane_err_channel_sel} == $past(reg_wdata[12:0], 2)) else $error("bkp select");
  a_loc_sat_hold: assert property (reg_rd && reg_addr == 16'h0028 ##1 reg_rdata == 16'hFFFF && !reg_wr
    ##1 reg_rd && reg_addr == 16'h0028 |=> reg_rdata == 16'hFFFF) else $error("local count wrapped");
  a_bkp_sat_hold: assert property (reg_rd && reg_addr == 16'h002A ##1 reg_rdata == 16'hFFFF && !reg_wr
    ##1 reg_rd && reg_addr == 16'h002A |=> reg_rdata == 16'hFFFF) else $error("backplane count wrapped");
endmodule : lab_regs_chk

bind lab_regs lab_regs_chk lab_regs_chk_inst
(
  .clk_sys                   (clk_sys),
  .rst_n                     (rst_n),
  .clk_en                    (clk_en),
  .reg_addr                  (reg_addr),
  .reg_wdata                 (reg_wdata),
  .reg_wr                    (reg_wr),
  .reg_rd                    (reg_rd),
  .reg_rdata                 (reg_rdata),
  .local_err_event           (local_err_event),
  .backplane_err_event       (backplane_err_event),
  .stream_advance_code       (stream_advance_code),
  .local_err_stream_sel      (local_err_stream_sel),
  .local_err_channel_sel     (local_err_channel_sel),
  .backplane_err_stream_sel  (backplane_err_stream_sel),
  .backplane_err_channel_sel (backplane_err_channel_sel)
);

/* File: dv/tb_lab_regs.sv */
/*
  Self-checking bench for the register bank.
  Assumes the checker is bound from its own file.
*/
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_lab_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        lerr = 1'b0;
  logic        berr = 1'b0;
  logic        ce = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [31:0] adv;
  logic [3:0]  ls;
  logic [4:0]  bs;
  logic [7:0]  lc, bc;
  logic [31:0] seed = 32'h02C1;
  logic [15:0] ra [4] = '{16'h0020, 16'h0021, 16'h0027, 16'h0029};
  logic [15:0] m [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  int          fail_count = 0;
  int          checked = 0;
  always #25 clk_sys = ~clk_sys;
  lab_regs lab_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .local_err_event(lerr),
    .backplane_err_event(berr), .stream_advance_code(adv), .local_err_stream_sel(ls),
    .local_err_channel_sel(lc), .backplane_err_stream_sel(bs), .backplane_err_channel_sel(bc));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [15:0] exp_word(input logic [1:0] k, input logic [15:0] v);
    return v & ((k == 2'h2) ? 16'h0FFF : (k == 2'h3) ? 16'h1FFF : 16'hFFFF);
  endfunction : exp_word
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge clk_sys);
  endtask : rd
  task automatic finish_test;
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial
  begin
    #4ms;
    fail_count++;
    finish_test();
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    foreach (ra[i]) rd(ra[i], 16'h0000);
    rd(16'h0030, 16'h0000);
    repeat (40)
    begin
      seed = xs(seed);
      m[seed[1:0]] = exp_word(seed[1:0], seed[31:16]);
      wr(ra[seed[1:0]], m[seed[1:0]]);
      rd(ra[seed[1:0]], m[seed[1:0]]);
      #1;
      `CHK(adv, {m[1], m[0]})
      `CHK({3'h0, bs, bc, 4'h0, ls, lc}, {m[3], m[2]})
      @(posedge clk_sys);
    end
    wr(16'h0020, 16'hA5C3);
    rd(16'h0020, 16'hA5C3);
    ce <= 1'b0;
    wr(16'h0020, 16'h5A3C);
    rd(16'h0020, 16'h0000);
    ce <= 1'b1;
    rd(16'h0020, 16'hA5C3);
    #1;
    `CHK(adv[15:0], 16'hA5C3)
    @(posedge clk_sys);
    for (int i = 0; i < 40; i++)
    begin
      lerr <= (i < int'(seed[4:0]));
      berr <= (i < int'(seed[9:5]));
      @(posedge clk_sys);
    end
    rd(16'h0028, {11'h000, seed[4:0]});
    rd(16'h002A, {11'h000, seed[9:5]});
    lerr <= 1'b1;
    berr <= 1'b1;
    repeat (65540) @(posedge clk_sys);
    rd(16'h0028, 16'hFFFF);
    rd(16'h0028, 16'hFFFF);
    rd(16'h002A, 16'hFFFF);
    rd(16'h002A, 16'hFFFF);
    lerr <= 1'b0;
    berr <= 1'b0;
    wr(16'h002C, 16'h0003);
    rd(16'h0028, 16'h0000);
    rd(16'h002A, 16'h0000);
    lerr <= 1'b1;
    wr(16'h002C, 16'h0002);
    lerr <= 1'b0;
    rd(16'h0028, 16'h0001);
    lerr <= 1'b1;
    wr(16'h002C, 16'h0001);
    lerr <= 1'b0;
    rd(16'h0028, 16'h0001);
    rd(16'h002A, 16'h0000);
    finish_test();
  end
endmodule : tb_lab_regs
